// [src/coproc_save_port.sv]
// Coprocessor side of the context-save handshake
module coproc_save_port #(
    parameter bit SECOND_VARIANT = 1'b0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic saveRd,
    input wire logic restoreActive,
    input wire logic restoreNull,
    input wire logic abortWr,
    input wire logic instrStart,
    input wire logic instrLong,
    input wire logic operandsDone,
    input wire logic checkpoint,
    input wire logic nearEnd,
    input wire logic instrDone,
    input wire logic opRd,
    input wire logic [31:0] frameWord,
    output logic saveValid,
    output logic [15:0] saveWord,
    output logic opValid,
    output logic [31:0] opData,
    output logic [5:0] frameIdx,
    output logic haltExec,
    output logic clearExc,
    output logic saveDone
);
    frame_if fr ();

    save_port_pkg::phase_t phase_q;
    logic ckptReq_q;
    logic stopped_q;
    logic saveValid_q;
    logic [15:0] saveWord_q;
    logic opValid_q;
    logic [31:0] opData_q;
    logic haltExec_q;
    logic clearExc_q;
    logic readOk;
    logic startIdle;
    logic startBusy;
    logic [15:0] fmtWord;
    logic [7:0] frameSize;

    frame_streamer u_streamer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .fr(fr)
    );

    // ------------------------------------------------------------
    // Save request decode
    // ------------------------------------------------------------
    // A read with no save or restore under way may start a frame
    assign readOk = saveRd && !fr.active && !restoreActive;
    assign startIdle = readOk && (phase_q == save_port_pkg::PH_IDLE);
    // busy frame at once in initial, or after checkpoint stop
    assign startBusy = readOk && ((phase_q == save_port_pkg::PH_INITIAL)
                       || (phase_q == save_port_pkg::PH_MIDDLE && stopped_q));

    assign fr.start = startIdle || startBusy;
    // busy frame length follows the variant size byte
    assign frameSize = save_port_pkg::sizeByte(SECOND_VARIANT, startBusy);
    assign fr.words = frameSize[7:2];
    // host abort ends a suspended save
    assign fr.abort = abortWr;
    // operand reads only count while a frame is open
    assign fr.adv = opRd && fr.active;

    // Format word selection
    // only five kinds ever leave
    always_comb begin
        fmtWord = {save_port_pkg::WAIT_HI, save_port_pkg::FILL_LO};
        if (saveRd && (fr.active || restoreActive)) begin
            fmtWord = {save_port_pkg::ILLEGAL_HI, save_port_pkg::FILL_LO};
        end else if (phase_q == save_port_pkg::PH_RESET) begin
            fmtWord = {save_port_pkg::NULL_HI, save_port_pkg::FILL_LO};
        end else if (startIdle || startBusy) begin
            // only the size byte differs per variant
            fmtWord = {save_port_pkg::VERSION,
                       save_port_pkg::sizeByte(SECOND_VARIANT, startBusy)};
        end
        // middle before checkpoint and end phase wait
        // fixed low byte for null, wait and illegal
    end

    // ------------------------------------------------------------
    // Execution phase tracking
    // ------------------------------------------------------------
    // Save completion outranks execution events since the core is halted
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= save_port_pkg::PH_RESET;
        end else if (restoreNull) begin
            phase_q <= save_port_pkg::PH_RESET;
        end else if (fr.done) begin
            phase_q <= save_port_pkg::PH_IDLE;
        end else if (!fr.active) begin
            unique case (phase_q)
                save_port_pkg::PH_RESET, save_port_pkg::PH_IDLE: begin
                    if (instrStart) begin
                        phase_q <= save_port_pkg::PH_INITIAL;
                    end
                end
                save_port_pkg::PH_INITIAL: begin
                    // only long operations have a middle phase
                    if (operandsDone) begin
                        phase_q <= instrLong ? save_port_pkg::PH_MIDDLE
                                             : save_port_pkg::PH_END;
                    end
                end
                save_port_pkg::PH_MIDDLE: begin
                    if (nearEnd && !stopped_q) begin
                        phase_q <= save_port_pkg::PH_END;
                    end
                end
                save_port_pkg::PH_END: begin
                    // finish, then idle frame on next read
                    if (instrDone) begin
                        phase_q <= save_port_pkg::PH_IDLE;
                    end
                end
            endcase
        end
    end

    // Pending save flag for the middle phase
    // flag between checkpoints
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ckptReq_q <= 1'b0;
        end else if (restoreNull || fr.done
                     || phase_q != save_port_pkg::PH_MIDDLE) begin
            ckptReq_q <= 1'b0;
        end else if (readOk && !stopped_q) begin
            ckptReq_q <= 1'b1;
        end
    end

    // Checkpoint stop, held until the busy frame is out
    // stop at next checkpoint
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stopped_q <= 1'b0;
        end else if (restoreNull || fr.done
                     || phase_q != save_port_pkg::PH_MIDDLE) begin
            stopped_q <= 1'b0;
        end else if (ckptReq_q && checkpoint) begin
            stopped_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register interface answers
    // ------------------------------------------------------------
    // answer one cycle after the read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            saveValid_q <= 1'b0;
            saveWord_q <= 16'h0000;
        end else begin
            saveValid_q <= saveRd;
            if (saveRd) begin
                saveWord_q <= fmtWord;
            end
        end
    end

    // Operand reads outside a frame get no answer
    // 32-bit frame words
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            opValid_q <= 1'b0;
            opData_q <= 32'h0000_0000;
        end else begin
            opValid_q <= fr.adv;
            if (fr.adv) begin
                opData_q <= frameWord;
            end
        end
    end

    // Core halt and exception clear; halt lags a cycle, the core only
    // needs it before its next checkpoint or operand
    // no pending exception after save
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            haltExec_q <= 1'b0;
            clearExc_q <= 1'b0;
        end else begin
            haltExec_q <= stopped_q || fr.active || fr.start;
            clearExc_q <= fr.done;
        end
    end

    assign saveValid = saveValid_q;
    assign saveWord = saveWord_q;
    assign opValid = opValid_q;
    assign opData = opData_q;
    assign frameIdx = fr.idx;
    assign haltExec = haltExec_q;
    assign clearExc = clearExc_q;
    assign saveDone = fr.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_readOk;
        saveRd && !fr.active && !restoreActive;
    endsequence

    property p_nullWord;
        @(posedge core_clk) disable iff (!arst_n)
        s_readOk and phase_q == save_port_pkg::PH_RESET |=>
            saveValid && saveWord[15:8] == save_port_pkg::NULL_HI
            && !fr.active;
    endproperty
    a_nullWord: assert property (p_nullWord)
        else $error("null phase did not answer null word");

    property p_illegal;
        @(posedge core_clk) disable iff (!arst_n)
        saveRd && (fr.active || restoreActive) |=>
            saveWord[15:8] == save_port_pkg::ILLEGAL_HI;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("nested save not answered illegal");

    property p_idleWord;
        @(posedge core_clk) disable iff (!arst_n)
        s_readOk and phase_q == save_port_pkg::PH_IDLE |=>
            saveWord == {save_port_pkg::VERSION,
                save_port_pkg::sizeByte(SECOND_VARIANT, 1'b0)} && fr.active;
    endproperty
    a_idleWord: assert property (p_idleWord)
        else $error("idle phase did not start idle frame");

    property p_busyInit;
        @(posedge core_clk) disable iff (!arst_n)
        s_readOk and phase_q == save_port_pkg::PH_INITIAL |=>
            saveWord[7:0] == save_port_pkg::sizeByte(SECOND_VARIANT, 1'b1)
            ##1 haltExec;
    endproperty
    a_busyInit: assert property (p_busyInit)
        else $error("initial phase did not start busy frame");

    property p_waitEnd;
        @(posedge core_clk) disable iff (!arst_n)
        s_readOk and phase_q == save_port_pkg::PH_END |=>
            saveWord == {save_port_pkg::WAIT_HI, save_port_pkg::FILL_LO};
    endproperty
    a_waitEnd: assert property (p_waitEnd)
        else $error("end phase did not answer wait");

    // Checkpoint arriving while a save is flagged, any distance after it
    sequence s_pendingCkpt;
        ckptReq_q && checkpoint && phase_q == save_port_pkg::PH_MIDDLE
        && !restoreNull && !fr.done;
    endsequence

    property p_ckptStop;
        @(posedge core_clk) disable iff (!arst_n)
        s_pendingCkpt |=> stopped_q ##1 haltExec;
    endproperty
    a_ckptStop: assert property (p_ckptStop)
        else $error("checkpoint did not stop after pending save");

    property p_doneIdle;
        @(posedge core_clk) disable iff (!arst_n)
        fr.done && !restoreNull |=>
            phase_q == save_port_pkg::PH_IDLE && clearExc && !fr.active;
    endproperty
    a_doneIdle: assert property (p_doneIdle)
        else $error("device not idle after last frame word");

    property p_opWord;
        @(posedge core_clk) disable iff (!arst_n)
        opRd && fr.active |=> opValid && opData == $past(frameWord);
    endproperty
    a_opWord: assert property (p_opWord)
        else $error("operand word not delivered");

    property p_fillLow;
        @(posedge core_clk) disable iff (!arst_n)
        saveValid && saveWord[15:8] <= save_port_pkg::ILLEGAL_HI |->
            saveWord[7:0] == save_port_pkg::FILL_LO;
    endproperty
    a_fillLow: assert property (p_fillLow)
        else $error("low byte of status word changed");

    property p_shortPath;
        @(posedge core_clk) disable iff (!arst_n)
        phase_q == save_port_pkg::PH_INITIAL && operandsDone && !instrLong
        && !fr.active && !restoreNull && !fr.done
        |=> phase_q == save_port_pkg::PH_END;
    endproperty
    a_shortPath: assert property (p_shortPath)
        else $error("short operation entered middle phase");
endmodule // coproc_save_port

// [src/save_port_pkg.sv]
// How it works
// - A save-register read answers with a valid format word once ready.
// - Not ready to stream yet means the wait-and-retry word, upper byte 01.
// - After idle or busy word, frame bytes leave operand register 32 bits each.
// - Only null, wait, illegal, idle or busy words are ever returned.
// - First variant: version byte, size 0x18 idle, 0xB4 busy.
// - Second variant: size 0x38 idle, 0xD4 busy; revisions alter version only.
// - Low byte of null, wait and illegal words is one fixed value.
// - Illegal word only when read during a save or restore in progress.
// - After last frame word device is idle, no pending exception.
// - Nothing run since reset or null restore gives null word at once.
// - Idle after some instruction gives idle word and idle frame at once.
// - While acquiring instruction and operands, busy word and frame at once.
// - Middle phase flags request, waits, stops at checkpoint, then busy frame.
// - Only long operations have a middle phase; others go initial to end.
// - End phase answers wait until completion, then saves an idle frame.
// - Busy frame is 180 bytes first variant, 212 bytes second.
package save_port_pkg;

    // ------------------------------------------------------------
    // Format word layout
    // ------------------------------------------------------------
    localparam logic [7:0] NULL_HI = 8'h00;
    localparam logic [7:0] WAIT_HI = 8'h01;
    localparam logic [7:0] ILLEGAL_HI = 8'h02;
    localparam logic [7:0] FILL_LO = 8'h00;
    // Version byte: arbitrary value
    localparam logic [7:0] VERSION = 8'h5A;

    // ------------------------------------------------------------
    // Frame size bytes (bytes after the format word)
    // ------------------------------------------------------------
    localparam logic [7:0] IDLE_SIZE_A = 8'h18;
    localparam logic [7:0] BUSY_SIZE_A = 8'hB4;
    localparam logic [7:0] IDLE_SIZE_B = 8'h38;
    localparam logic [7:0] BUSY_SIZE_B = 8'hD4;

    localparam int WORD_W = 6;
    localparam logic [WORD_W-1:0] IDX_RESET = 6'h00;

    typedef enum logic [2:0] {
        PH_RESET,
        PH_IDLE,
        PH_INITIAL,
        PH_MIDDLE,
        PH_END
    } phase_t;

    // Size byte for the chosen variant and frame kind
    function automatic logic [7:0] sizeByte(input logic secondVar,
                                            input logic busy);
        if (secondVar)
            sizeByte = busy ? BUSY_SIZE_B : IDLE_SIZE_B;
        else
            sizeByte = busy ? BUSY_SIZE_A : IDLE_SIZE_A;
    endfunction

endpackage

// [src/frame_if.sv]
// Link between the save controller and the frame streamer
interface frame_if;
    logic start;
    logic abort;
    logic adv;
    logic [save_port_pkg::WORD_W-1:0] words;
    logic active;
    logic done;
    logic [save_port_pkg::WORD_W-1:0] idx;

    modport ctrl (
        output start,
        output abort,
        output adv,
        output words,
        input active,
        input done,
        input idx
    );
    modport strm (
        input start,
        input abort,
        input adv,
        input words,
        output active,
        output done,
        output idx
    );
endinterface

// [src/frame_streamer.sv]
// Counts frame words out through the operand register
module frame_streamer (
    input wire logic core_clk,
    input wire logic arst_n,
    frame_if.strm fr
);
    logic active_q;
    logic done_q;
    logic [save_port_pkg::WORD_W-1:0] idx_q;
    logic [save_port_pkg::WORD_W-1:0] words_q;

    assign fr.active = active_q;
    assign fr.done = done_q;
    assign fr.idx = idx_q;

    // ------------------------------------------------------------
    // Word counter
    // ------------------------------------------------------------
    // one word per read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= 1'b0;
            idx_q <= save_port_pkg::IDX_RESET;
            words_q <= save_port_pkg::IDX_RESET;
        end else if (fr.abort) begin
            active_q <= 1'b0; // Abort drops the rest of the frame
        end else if (fr.start) begin
            active_q <= 1'b1;
            idx_q <= save_port_pkg::IDX_RESET;
            words_q <= fr.words;
        end else if (fr.adv && active_q) begin
            if (idx_q == words_q - 6'h01) begin
                active_q <= 1'b0;
            end else begin
                idx_q <= idx_q + 6'h01;
            end
        end
    end

    // Completion pulse after the last word leaves
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= fr.adv && active_q && !fr.abort && !fr.start
                      && (idx_q == words_q - 6'h01);
        end
    end
endmodule // frame_streamer

// [sim/host_model.sv]
// Host side of the save handshake: reads save and operand registers
module host_model #(
    parameter logic [31:0] PAT = 32'hC0DE0000
) (
    input wire logic core_clk,
    input wire logic saveValid,
    input wire logic [15:0] saveWord,
    input wire logic opValid,
    input wire logic [31:0] opData,
    input wire logic saveDone,
    output logic saveRd,
    output logic opRd,
    output logic abortWr
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] fmtSeen;
    logic [31:0] frameMem [0:63];
    int waits;
    int validCnt;
    int badWords;
    logic doneSeen;

    initial begin
        saveRd = 1'b0;
        opRd = 1'b0;
        abortWr = 1'b0;
    end

    // ------------------------------------------------------------
    // Single accesses
    // ------------------------------------------------------------
    // save read
    task automatic read_save();
        @(posedge core_clk);
        #1 saveRd = 1'b1;
        @(posedge core_clk);
        #1 saveRd = 1'b0;
        // Answer stands one cycle only, so it is taken here
        fmtSeen = saveValid ? saveWord : 16'hFFFF;
    endtask

    task automatic pulse_abort();
        @(posedge core_clk);
        #1 abortWr = 1'b1;
        @(posedge core_clk);
        #1 abortWr = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Frame transfer, one 32-bit word per read
    // ------------------------------------------------------------
    // descending fill
    task automatic read_frame(input int n);
        validCnt = 0;
        badWords = 0;
        doneSeen = 1'b0;
        frameMem[0] = {16'h0000, fmtSeen};
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            #1 opRd = 1'b1;
            @(posedge core_clk);
            #1 opRd = 1'b0;
            if (opValid === 1'b1) begin
                validCnt++;
                frameMem[n - i] = opData; // Highest address first
                if (opData !== (PAT | 32'(i)))
                    badWords++;
                if (i == n - 1)
                    doneSeen = (saveDone === 1'b1);
            end
        end
        // no further save or response read after the frame
    endtask

    task automatic full_save(input int maxWaits);
        waits = 0;
        read_save();
        while (fmtSeen[15:8] === 8'h01 && waits < maxWaits) begin
            waits++;
            read_save();
        end
        if (fmtSeen[15:8] === 8'h02)
            pulse_abort();
        else if (fmtSeen[15:8] === save_port_pkg::VERSION)
            read_frame(int'(fmtSeen[7:0]) / 4);
    endtask
endmodule // host_model

// [sim/coprocessor_state_save_protocol_bench.sv]
// Self-checking bench for the save port
module coprocessor_state_save_protocol_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] PAT = 32'hC0DE0000;

    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic saveRd, restoreActive = 1'b0, restoreNull = 1'b0;
    logic abortWr, instrStart = 1'b0, instrLong = 1'b0;
    logic operandsDone = 1'b0, checkpoint = 1'b0, nearEnd = 1'b0;
    logic instrDone = 1'b0, opRd;
    logic [31:0] frameWord;
    logic saveValid, opValid, haltExec, clearExc, saveDone;
    logic [15:0] saveWord, saveWordB;
    logic saveValidB, opValidB, haltExecB, clearExcB, saveDoneB;
    logic [31:0] opData, opDataB;
    logic [5:0] frameIdx, frameIdxB;
    int fails = 0;
    int samples_checked = 0;

    always #4 core_clk = ~core_clk;

    // Far side supplies a word tagged with its own index
    assign frameWord = PAT | {26'h0, frameIdx};

    coproc_save_port #(.SECOND_VARIANT(1'b0)) dut_u (.core_clk(core_clk),
        .arst_n(arst_n), .saveRd(saveRd), .restoreActive(restoreActive),
        .restoreNull(restoreNull), .abortWr(abortWr),
        .instrStart(instrStart), .instrLong(instrLong),
        .operandsDone(operandsDone), .checkpoint(checkpoint),
        .nearEnd(nearEnd), .instrDone(instrDone), .opRd(opRd),
        .frameWord(frameWord), .saveValid(saveValid), .saveWord(saveWord),
        .opValid(opValid), .opData(opData), .frameIdx(frameIdx),
        .haltExec(haltExec), .clearExc(clearExc), .saveDone(saveDone));

    // Second variant shares every input; its word and frame are watched
    coproc_save_port #(.SECOND_VARIANT(1'b1)) dutB_u (.core_clk(core_clk),
        .arst_n(arst_n), .saveRd(saveRd), .restoreActive(restoreActive),
        .restoreNull(restoreNull), .abortWr(abortWr),
        .instrStart(instrStart), .instrLong(instrLong),
        .operandsDone(operandsDone), .checkpoint(checkpoint),
        .nearEnd(nearEnd), .instrDone(instrDone), .opRd(opRd),
        .frameWord(frameWord), .saveValid(saveValidB),
        .saveWord(saveWordB), .opValid(opValidB), .opData(opDataB),
        .frameIdx(frameIdxB), .haltExec(haltExecB), .clearExc(clearExcB),
        .saveDone(saveDoneB));

    host_model #(.PAT(PAT)) host_u (.core_clk(core_clk),
        .saveValid(saveValid), .saveWord(saveWord), .opValid(opValid),
        .opData(opData), .saveDone(saveDone), .saveRd(saveRd),
        .opRd(opRd), .abortWr(abortWr));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle pulse on core events: null restore, start, operands,
    // checkpoint, near end, done
    task automatic ev(input logic [5:0] m);
        @(posedge core_clk);
        #1 {restoreNull, instrStart, operandsDone, checkpoint, nearEnd,
            instrDone} = m;
        @(posedge core_clk);
        #1 {restoreNull, instrStart, operandsDone, checkpoint, nearEnd,
            instrDone} = 6'h00;
    endtask

    task automatic close_out();
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_null();
        host_u.read_save();
        check("null word", 32'(host_u.fmtSeen), 32'h0000);
        host_u.read_frame(1);
        check("op without frame", host_u.validCnt, 0);
    endtask

    task automatic t_short();
        ev(6'h10);
        ev(6'h08); // Short operation: no middle phase
        ev(6'h04); // Checkpoint must not open a busy frame here
        host_u.read_save();
        check("short end wait", 32'(host_u.fmtSeen), 32'h0100);
        ev(6'h01);
        host_u.read_save();
        check("idle word", 32'(host_u.fmtSeen), 32'h5A18);
        check("idle word B", 32'(saveWordB), 32'h5A38);
        check("valid B", 32'(saveValidB), 1);
        host_u.read_frame(6);
        check("idle words", host_u.validCnt, 6);
        check("idle data", host_u.badWords, 0);
        check("last word done", 32'(host_u.doneSeen), 1);
        @(posedge core_clk);
        #1 check("clear exc", 32'(clearExc), 1);
        check("halt released", 32'(haltExec), 0);
        host_u.pulse_abort(); // Closes the longer frame of variant B
        host_u.read_save();
        check("idle after save", 32'(host_u.fmtSeen), 32'h5A18);
        host_u.pulse_abort();
    endtask

    task automatic t_initial();
        ev(6'h10);
        host_u.read_save();
        check("busy word", 32'(host_u.fmtSeen), 32'h5AB4);
        check("busy word B", 32'(saveWordB), 32'h5AD4);
        check("halt on busy", 32'(haltExec), 1);
        host_u.read_frame(45);
        check("busy words", host_u.validCnt, 45);
        check("busy data", host_u.badWords, 0);
        // Longer frame of variant B is still open after 45 words
        check("B index", 32'(frameIdxB), 45);
        check("B word taken", 32'(opValidB), 1);
        check("B word", opDataB, PAT | 32'd44);
        check("B open", {haltExecB, saveDoneB, clearExcB}, 32'h4);
        host_u.pulse_abort();
    endtask

    task automatic t_middle();
        instrLong = 1'b1;
        ev(6'h10);
        ev(6'h08);
        host_u.read_save();
        check("middle wait", 32'(host_u.fmtSeen), 32'h0100);
        host_u.read_save();
        check("wait repeat", 32'(host_u.fmtSeen), 32'h0100);
        ev(6'h04);
        host_u.read_save();
        check("checkpoint busy", 32'(host_u.fmtSeen), 32'h5AB4);
        host_u.read_frame(45);
        check("checkpoint frame", host_u.validCnt, 45);
        host_u.pulse_abort();
    endtask

    task automatic t_end();
        ev(6'h10);
        ev(6'h08);
        ev(6'h02);
        host_u.read_save();
        check("end wait", 32'(host_u.fmtSeen), 32'h0100);
        ev(6'h01);
        host_u.read_save();
        check("end idle", 32'(host_u.fmtSeen), 32'h5A18);
        host_u.read_frame(6);
        check("end frame", host_u.validCnt, 6);
        instrLong = 1'b0;
        host_u.pulse_abort();
    endtask

    task automatic t_illegal();
        host_u.read_save();
        host_u.read_frame(2); // Save left two of six words done
        host_u.full_save(0);
        check("nested save", 32'(host_u.fmtSeen), 32'h0200);
        host_u.read_frame(1);
        check("aborted frame", host_u.validCnt, 0);
        restoreActive = 1'b1;
        host_u.read_save();
        check("during restore", 32'(host_u.fmtSeen), 32'h0200);
        restoreActive = 1'b0;
    endtask

    task automatic t_restore_null();
        ev(6'h20);
        host_u.read_save();
        check("null after restore", 32'(host_u.fmtSeen), 32'h0000);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        #1 arst_n = 1'b1;
        t_null();
        t_short();
        t_initial();
        t_middle();
        t_end();
        t_illegal();
        t_restore_null();
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        fails++;
        close_out();
    end
endmodule // coprocessor_state_save_protocol_bench
